// ### pkg/cbi_irq_if.sv
`timescale 1ns/1ps
interface cbi_irq_if;
	import cbi_pkg::*;
	logic             smp;
	logic             int_n;
	logic             nmi_n;
	logic             en_set;
	logic             en_clr;
	logic             im_wr;
	cbi_mode_type     im_val;
	logic             ivr_wr;
	logic [IVR_W-1:0] ivr_val;
	logic             take_nmi;
	logic             take_int;
	cbi_mode_type     im;
	logic [IVR_W-1:0] ivr;

	modport ctl (
		input  smp, int_n, nmi_n, en_set, en_clr, im_wr, im_val, ivr_wr, ivr_val,
		output take_nmi, take_int, im, ivr
	);
	modport seq (
		output smp, int_n, nmi_n, en_set, en_clr, im_wr, im_val, ivr_wr, ivr_val,
		input  take_nmi, take_int, im, ivr
	);
endinterface : cbi_irq_if

// ### pkg/cbi_pkg.sv
package cbi_pkg;
	localparam int          ADDR_W    = 16;
	localparam int          DATA_W    = 8;
	localparam int          REFRESH_CYCLE_FLAG_W    = 7;
	localparam int          IVR_W     = 8;
	localparam logic [15:0] RST_PC    = 16'h0000;
	localparam logic [15:0] NMI_ADDR  = 16'h0066;
	localparam logic [15:0] IM1_ADDR  = 16'h0038;
	localparam logic [7:0]  RST_IVR   = 8'h00;
	localparam logic [6:0]  RST_REFRESH_CYCLE_FLAG  = 7'h00;
	localparam logic [6:0]  REFRESH_CYCLE_FLAG_STEP = 7'h01;
	localparam logic [15:0] PC_STEP   = 16'h0001;
	localparam logic [1:0]  IO_WAITS  = 2'h1;
	localparam logic [1:0]  ACK_WAITS = 2'h2;

	typedef enum logic [1:0] {
		IM_0 = 2'h0,
		IM_1 = 2'h1,
		IM_2 = 2'h2
	} cbi_mode_type;

	typedef enum logic [2:0] {
		K_FETCH = 3'h0,
		K_MRD   = 3'h1,
		K_MWR   = 3'h2,
		K_IORD  = 3'h3,
		K_IOWR  = 3'h4,
		K_ACK   = 3'h5
	} cbi_kind_type;

	// Gray steps along T1, T2, auto wait, wait, T3, T4.
	typedef enum logic [2:0] {
		S_T1   = 3'h0,
		S_T2   = 3'h1,
		S_TA   = 3'h3,
		S_TW   = 3'h2,
		S_T3   = 3'h6,
		S_T4   = 3'h7,
		S_BUS  = 3'h5,
		S_IDLE = 3'h4
	} cbi_state_type;
endpackage : cbi_pkg

// ### rtl/cbi_bus_seq.sv
// Functional notes
// - Drive 16-bit tri-state address bus.
// - Share 8-bit tri-state bidirectional data bus.
// - Fetch-cycle flag low only during opcode fetch and interrupt acknowledge.
// - Memory request only with valid memory address.
// - I/O request for ports and interrupt acknowledge.
// - Read strobe gates partner data onto bus.
// - Write strobe only while write data stable.
// - Refresh flag with refresh address, low seven bits.
// - Halt output, no-op fetches until interrupt.
// - Wait input low keeps inserting wait states.
// - Maskable request taken only when latch enabled.
// - Non-maskable request always taken, restart 0066H.
// - Reset clears latch, PC, page, refresh counter.
// - During reset float buses, controls inactive.
// - Bus takeover at cycle end floats everything.
// - Acknowledge only after outputs are floated.
// - Fetch address first, memory request half later.
// - Capture opcode at rising edge of T3.
// - T3 and T4 of fetch refresh memory.
// - One automatic wait state in I/O cycles.
// - Sample interrupts at instruction's final clock.
// - Acknowledge fetch uses I/O request, two waits.
// - Vectored mode pointer is page then vector.
// - Three interrupt modes: 0, 1 and 2.
`timescale 1ns/1ps
module cbi_bus_seq
	import cbi_pkg::*;
(
	// Clock and reset
	input  wire logic              i_ref_clk,
	input  wire logic              i_sys_rst,
	// Core request port
	input  wire logic              i_cyc_req,
	input  wire cbi_kind_type      i_cyc_kind,
	input  wire logic [ADDR_W-1:0] i_cyc_addr,
	input  wire logic [DATA_W-1:0] i_cyc_wdata,
	input  wire logic              i_instr_last,
	input  wire logic              i_halt_exec,
	input  wire logic              i_pc_load,
	input  wire logic [ADDR_W-1:0] i_pc_val,
	// Interrupt control
	input  wire logic              i_irq_en_set,
	input  wire logic              i_irq_en_clr,
	input  wire logic              i_im_wr,
	input  wire cbi_mode_type      i_im_val,
	input  wire logic              i_ivr_wr,
	input  wire logic [IVR_W-1:0]  i_ivr_val,
	// Core answer port
	output logic                   o_cyc_done,
	output logic [DATA_W-1:0]      o_rdata,
	output logic [ADDR_W-1:0]      o_pc,
	output logic                   o_irq_take,
	output logic                   o_irq_nmi,
	output logic [ADDR_W-1:0]      o_irq_target,
	output cbi_mode_type           o_irq_mode,
	// Bus pins
	output logic [ADDR_W-1:0]      o_addr,
	output logic                   o_addr_oe,
	input  wire logic [DATA_W-1:0] i_data,
	output logic [DATA_W-1:0]      o_data,
	output logic                   o_data_oe,
	output logic                   o_ctl_oe,
	output logic                   o_fetch_n,
	output logic                   o_memory_request_n,
	output logic                   o_io_request_n,
	output logic                   o_rd_n,
	output logic                   o_wr_n,
	output logic                   o_refresh_cycle_flag_n,
	output logic                   o_halt_n,
	output logic                   o_bus_release_ack_n,
	input  wire logic              i_wait_n,
	input  wire logic              i_int_n,
	input  wire logic              i_nmi_n,
	input  wire logic              i_bus_takeover_request_n
);
	cbi_irq_if irq ();

	cbi_irq_ctl u_irq (
		.i_ref_clk (i_ref_clk),
		.i_sys_rst (i_sys_rst),
		.irq       (irq.ctl)
	);

	assign irq.int_n   = i_int_n;
	assign irq.nmi_n   = i_nmi_n;
	assign irq.en_set  = i_irq_en_set;
	assign irq.en_clr  = i_irq_en_clr;
	assign irq.im_wr   = i_im_wr;
	assign irq.im_val  = i_im_val;
	assign irq.ivr_wr  = i_ivr_wr;
	assign irq.ivr_val = i_ivr_val;

	// Sequencer state.
	cbi_state_type      state_ff, nxt_state;
	cbi_kind_type       kind_ff, nxt_kind;
	logic               ph_ff, nxt_ph;
	logic [1:0]         aw_ff, nxt_aw;
	logic [ADDR_W-1:0]  addr_ff, nxt_addr;
	logic [DATA_W-1:0]  wdat_ff, nxt_wdat;
	logic [DATA_W-1:0]  rdat_ff, nxt_rdat;
	logic [ADDR_W-1:0]  pc_ff, nxt_pc;
	logic [REFRESH_CYCLE_FLAG_W-1:0]  refresh_cycle_flag_ff, nxt_refresh_cycle_flag;
	logic               last_ff, nxt_last;
	logic               halt_ff, nxt_halt;
	logic               ackp_ff, nxt_ackp;
	logic               fin;
	logic [1:0]         waits;
	// Pin and answer registers.
	logic [ADDR_W-1:0]  pa_ff, nxt_pa;
	logic               aoe_ff, nxt_aoe, doe_ff, nxt_doe;
	logic               m1_ff, nxt_m1, mrq_ff, nxt_mrq, io_request_ff, nxt_io_request;
	logic               rd_ff, nxt_rd, wr_ff, nxt_wr, rf_ff, nxt_rf;
	logic               hlt_ff, nxt_hlt, bak_ff, nxt_bak;
	logic               fch, io, mem, early, t1b, t3a, rfw, rfm, busy;
	logic               done_ff, nxt_done, take_ff, nxt_take, nmi_ff, nxt_nmi;
	logic [ADDR_W-1:0]  tgt_ff, nxt_tgt;
	cbi_mode_type       mode_ff, nxt_mode;

	always_comb begin
		nxt_state = state_ff;
		nxt_kind  = kind_ff;
		nxt_ph    = 1'b0;
		nxt_aw    = aw_ff;
		nxt_addr  = addr_ff;
		nxt_wdat  = wdat_ff;
		nxt_pc    = pc_ff;
		nxt_refresh_cycle_flag  = refresh_cycle_flag_ff;
		nxt_last  = last_ff;
		fin       = 1'b0;
		waits     = (kind_ff == K_ACK) ? ACK_WAITS : IO_WAITS;
		if (state_ff != S_IDLE && state_ff != S_BUS) begin
			nxt_ph = ~ph_ff;
		end
		case (state_ff)
			S_IDLE: begin
				// Takeover outranks every other start, so it is seen at each cycle end.
				if (!i_bus_takeover_request_n) begin
					nxt_state = S_BUS;
				end else if (ackp_ff) begin
					nxt_state = S_T1;
					nxt_kind  = K_ACK;
					nxt_addr  = pc_ff;
					nxt_last  = 1'b0;
				end else if (halt_ff) begin
					nxt_state = S_T1;
					nxt_kind  = K_FETCH;
					nxt_addr  = pc_ff;
					nxt_last  = 1'b1;
				end else if (i_cyc_req && !done_ff && !take_ff) begin
					nxt_state = S_T1;
					nxt_kind  = i_cyc_kind;
					nxt_addr  = (i_cyc_kind == K_FETCH) ? pc_ff : i_cyc_addr;
					nxt_wdat  = i_cyc_wdata;
					nxt_last  = i_instr_last;
				end
			end
			S_T1: begin
				if (ph_ff) begin
					nxt_state = S_T2;
				end
			end
			S_T2: begin
				if (ph_ff) begin
					if (kind_ff inside {K_IORD, K_IOWR, K_ACK}) begin
						nxt_state = S_TA;
						nxt_aw    = 2'h1;
					end else begin
						nxt_state = i_wait_n ? S_T3 : S_TW;
					end
				end
			end
			S_TA: begin
				if (ph_ff) begin
					if (aw_ff != waits) begin
						nxt_aw = aw_ff + 2'h1;
					end else begin
						nxt_state = i_wait_n ? S_T3 : S_TW;
					end
				end
			end
			S_TW: begin
				if (ph_ff && i_wait_n) begin
					nxt_state = S_T3;
				end
			end
			S_T3: begin
				if (ph_ff) begin
					if (kind_ff == K_FETCH || kind_ff == K_ACK) begin
						nxt_state = S_T4;
					end else begin
						fin = 1'b1;
					end
				end
			end
			S_T4: begin
				if (ph_ff) begin
					fin      = 1'b1;
					nxt_refresh_cycle_flag = refresh_cycle_flag_ff + REFRESH_CYCLE_FLAG_STEP;
				end
			end
			S_BUS: begin
				if (i_bus_takeover_request_n) begin
					nxt_state = S_IDLE;
				end
			end
			default: begin
				nxt_state = S_IDLE;
			end
		endcase
		if (fin) begin
			nxt_state = S_IDLE;
			if (kind_ff == K_FETCH && !halt_ff) begin
				nxt_pc = pc_ff + PC_STEP;
			end
		end
		if (i_pc_load) begin
			nxt_pc = i_pc_val;
		end
		// Interrupts are looked at only on the last clock of an instruction.
		irq.smp  = fin && last_ff;
		nxt_ackp = (ackp_ff && !(state_ff == S_IDLE && i_bus_takeover_request_n)) || irq.take_int;
		nxt_halt = (halt_ff || i_halt_exec) && !irq.take_nmi && !irq.take_int;
		nxt_rdat = (nxt_state == S_T3 && state_ff != S_T3) ? i_data : rdat_ff;
	end

	always_comb begin
		fch   = nxt_kind == K_FETCH || nxt_kind == K_ACK;
		io    = nxt_kind == K_IORD || nxt_kind == K_IOWR;
		mem   = nxt_kind inside {K_FETCH, K_MRD, K_MWR};
		busy  = nxt_state != S_IDLE && nxt_state != S_BUS;
		early = nxt_state inside {S_T2, S_TA, S_TW};
		t1b   = nxt_state == S_T1 && nxt_ph;
		t3a   = nxt_state == S_T3 && !nxt_ph;
		rfw   = busy && fch && (nxt_state == S_T3 || nxt_state == S_T4);
		rfm   = rfw && (nxt_state == S_T3 ? nxt_ph : !nxt_ph);
		// Refresh slots carry page and counter; the counter sits in the low bits.
		nxt_pa   = rfw ? {irq.ivr, 1'b0, refresh_cycle_flag_ff} : nxt_addr;
		nxt_aoe  = nxt_state != S_BUS;
		nxt_doe  = busy && (nxt_kind == K_MWR || nxt_kind == K_IOWR) && !(nxt_state == S_T1 && !nxt_ph);
		nxt_m1   = !(busy && fch && !rfw);
		nxt_mrq  = !(busy && ((mem && (t1b || early || (!fch && t3a))) || rfm));
		nxt_rf   = !rfw;
		nxt_rd   = !(busy && (((nxt_kind == K_FETCH || nxt_kind == K_MRD) && (t1b || early))
			|| ((nxt_kind == K_MRD || nxt_kind == K_IORD) && t3a) || (nxt_kind == K_IORD && early)));
		nxt_io_request = !(busy && ((io && (early || t3a)) || (nxt_kind == K_ACK
			&& (nxt_state == S_TW || (nxt_state == S_TA && nxt_aw == ACK_WAITS)))));
		nxt_wr   = !(busy && ((nxt_kind == K_MWR && ((nxt_state == S_T2 && nxt_ph) || nxt_state == S_TW || t3a))
			|| (nxt_kind == K_IOWR && (early || t3a))));
		nxt_hlt  = !nxt_halt;
		// Acknowledge trails the float by one clock so no two drivers overlap.
		nxt_bak  = !(state_ff == S_BUS && nxt_state == S_BUS);
		nxt_done = fin && kind_ff != K_ACK && !halt_ff;
		nxt_take = (fin && kind_ff == K_ACK) || irq.take_nmi;
		nxt_nmi  = irq.take_nmi;
		nxt_mode = irq.im;
		case (irq.im)
			IM_1: nxt_tgt = IM1_ADDR;
			IM_2: nxt_tgt = {irq.ivr, rdat_ff};
			default: nxt_tgt = {8'h00, rdat_ff};
		endcase
		if (irq.take_nmi) begin
			nxt_tgt = NMI_ADDR;
		end
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			state_ff <= S_IDLE;
			kind_ff  <= K_FETCH;
			ph_ff    <= 1'b0;
			aw_ff    <= 2'h0;
			addr_ff  <= RST_PC;
			wdat_ff  <= 8'h00;
			rdat_ff  <= 8'h00;
			pc_ff    <= RST_PC;
			refresh_cycle_flag_ff  <= RST_REFRESH_CYCLE_FLAG;
			last_ff  <= 1'b0;
			halt_ff  <= 1'b0;
			ackp_ff  <= 1'b0;
			pa_ff    <= RST_PC;
			aoe_ff   <= 1'b0;
			doe_ff   <= 1'b0;
			m1_ff    <= 1'b1;
			mrq_ff   <= 1'b1;
			io_request_ff  <= 1'b1;
			rd_ff    <= 1'b1;
			wr_ff    <= 1'b1;
			rf_ff    <= 1'b1;
			hlt_ff   <= 1'b1;
			bak_ff   <= 1'b1;
			done_ff  <= 1'b0;
			take_ff  <= 1'b0;
			nmi_ff   <= 1'b0;
			tgt_ff   <= RST_PC;
			mode_ff  <= IM_0;
		end else begin
			state_ff <= nxt_state;
			kind_ff  <= nxt_kind;
			ph_ff    <= nxt_ph;
			aw_ff    <= nxt_aw;
			addr_ff  <= nxt_addr;
			wdat_ff  <= nxt_wdat;
			rdat_ff  <= nxt_rdat;
			pc_ff    <= nxt_pc;
			refresh_cycle_flag_ff  <= nxt_refresh_cycle_flag;
			last_ff  <= nxt_last;
			halt_ff  <= nxt_halt;
			ackp_ff  <= nxt_ackp;
			pa_ff    <= nxt_pa;
			aoe_ff   <= nxt_aoe;
			doe_ff   <= nxt_doe;
			m1_ff    <= nxt_m1;
			mrq_ff   <= nxt_mrq;
			io_request_ff  <= nxt_io_request;
			rd_ff    <= nxt_rd;
			wr_ff    <= nxt_wr;
			rf_ff    <= nxt_rf;
			hlt_ff   <= nxt_hlt;
			bak_ff   <= nxt_bak;
			done_ff  <= nxt_done;
			take_ff  <= nxt_take;
			nmi_ff   <= nxt_nmi;
			tgt_ff   <= nxt_tgt;
			mode_ff  <= nxt_mode;
		end
	end

	assign o_addr       = pa_ff;
	assign o_addr_oe    = aoe_ff;
	assign o_ctl_oe     = aoe_ff;
	assign o_data       = wdat_ff;
	assign o_data_oe    = doe_ff;
	assign o_fetch_n    = m1_ff;
	assign o_memory_request_n     = mrq_ff;
	assign o_io_request_n     = io_request_ff;
	assign o_rd_n       = rd_ff;
	assign o_wr_n       = wr_ff;
	assign o_refresh_cycle_flag_n     = rf_ff;
	assign o_halt_n     = hlt_ff;
	assign o_bus_release_ack_n    = bak_ff;
	assign o_cyc_done   = done_ff;
	assign o_rdata      = rdat_ff;
	assign o_pc         = pc_ff;
	assign o_irq_take   = take_ff;
	assign o_irq_nmi    = nmi_ff;
	assign o_irq_target = tgt_ff;
	assign o_irq_mode   = mode_ff;

	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (i_sys_rst);

	sequence s_fetch_t1;
		state_ff == S_T1 && !ph_ff && kind_ff == K_FETCH;
	endsequence
	sequence s_memory_request_half;
		o_memory_request_n && !o_fetch_n ##1 !o_memory_request_n && !o_rd_n;
	endsequence
	sequence s_io_t2_end;
		state_ff == S_T2 && ph_ff && kind_ff inside {K_IORD, K_IOWR};
	endsequence

	a_float_on_reset: assert property (disable iff (1'b0) i_sys_rst |=> !o_addr_oe && !o_data_oe && o_memory_request_n && o_rd_n)
		else $error("buses driven or strobes active after reset");
	a_bus_release_ack_after_float: assert property ($fell(o_bus_release_ack_n) |-> $past(!o_ctl_oe) && !o_addr_oe && !o_data_oe)
		else $error("acknowledge given before outputs floated");
	a_takeover_float: assert property (state_ff == S_IDLE && !i_bus_takeover_request_n |=> !o_addr_oe && !o_ctl_oe)
		else $error("takeover request did not float the bus");
	a_resume_bus: assert property (!o_bus_release_ack_n && i_bus_takeover_request_n |=> o_bus_release_ack_n && o_addr_oe)
		else $error("bus not resumed after takeover ended");
	a_memory_request_half_t: assert property (s_fetch_t1 |-> s_memory_request_half)
		else $error("fetch memory request not half a state after address");
	a_refresh_slot: assert property (state_ff == S_T3 && kind_ff == K_FETCH |-> !o_refresh_cycle_flag_n && o_fetch_n && o_addr[6:0] == refresh_cycle_flag_ff)
		else $error("fetch T3 without refresh address");
	a_io_auto_wait: assert property (s_io_t2_end |=> (state_ff == S_TA)[*2] ##1 state_ff != S_TA)
		else $error("I/O cycle lacks exactly one automatic wait");
	a_ack_two_waits: assert property (state_ff == S_T2 && ph_ff && kind_ff == K_ACK |=> (state_ff == S_TA)[*4])
		else $error("acknowledge cycle lacks two automatic waits");
	a_ack_io_request: assert property (state_ff == S_TA && kind_ff == K_ACK && aw_ff == ACK_WAITS |-> !o_io_request_n && o_memory_request_n)
		else $error("acknowledge cycle not using I/O request");
	a_wait_holds: assert property (state_ff == S_TW && ph_ff && !i_wait_n |=> state_ff == S_TW)
		else $error("wait state left while wait input low");
	a_opcode_capture: assert property (state_ff == S_T3 && $past(state_ff) != S_T3 |-> rdat_ff == $past(i_data))
		else $error("data not captured at T3 entry");
	a_nmi_restart: assert property (irq.take_nmi |=> o_irq_take && o_irq_nmi && o_irq_target == NMI_ADDR)
		else $error("non-maskable restart address wrong");
	a_write_strobe: assert property (!o_wr_n |-> o_data_oe && o_ctl_oe)
		else $error("write strobe without driven data");
endmodule : cbi_bus_seq

// ### rtl/cbi_irq_ctl.sv
`timescale 1ns/1ps
module cbi_irq_ctl
	import cbi_pkg::*;
(
	// Clock and reset
	input  wire logic i_ref_clk,
	input  wire logic i_sys_rst,
	// Sequencer side
	cbi_irq_if.ctl    irq
);
	logic             iff_ff;
	logic             nxt_iff;
	cbi_mode_type     im_ff;
	cbi_mode_type     nxt_im;
	logic [IVR_W-1:0] ivr_ff;
	logic [IVR_W-1:0] nxt_ivr;
	logic             nmi_prev_ff;
	logic             nxt_nmi_prev;
	logic             nmi_pend_ff;
	logic             nxt_nmi_pend;

	always_comb begin
		// The non-maskable path never looks at the enable latch.
		irq.take_nmi = irq.smp && nmi_pend_ff;
		irq.take_int = irq.smp && !nmi_pend_ff && !irq.int_n && iff_ff;
		nxt_nmi_prev = irq.nmi_n;
		// A new falling edge in the taking cycle stays pending.
		nxt_nmi_pend = (nmi_pend_ff && !irq.take_nmi) || (nmi_prev_ff && !irq.nmi_n);
		nxt_iff = iff_ff;
		if (irq.en_set) begin
			nxt_iff = 1'b1;
		end
		if (irq.en_clr || irq.take_nmi || irq.take_int) begin
			nxt_iff = 1'b0;
		end
		nxt_im = irq.im_wr ? irq.im_val : im_ff;
		nxt_ivr = irq.ivr_wr ? irq.ivr_val : ivr_ff;
	end

	always_ff @(posedge i_ref_clk) begin
		if (i_sys_rst) begin
			iff_ff      <= 1'b0;
			im_ff       <= IM_0;
			ivr_ff      <= RST_IVR;
			nmi_prev_ff <= 1'b1;
			nmi_pend_ff <= 1'b0;
		end else begin
			iff_ff      <= nxt_iff;
			im_ff       <= nxt_im;
			ivr_ff      <= nxt_ivr;
			nmi_prev_ff <= nxt_nmi_prev;
			nmi_pend_ff <= nxt_nmi_pend;
		end
	end

	assign irq.im  = im_ff;
	assign irq.ivr = ivr_ff;

	a_reset_state: assert property (@(posedge i_ref_clk) i_sys_rst |=> !iff_ff && im_ff == IM_0 && ivr_ff == RST_IVR)
		else $error("interrupt state not cleared by reset");
	a_take_clears: assert property (@(posedge i_ref_clk) disable iff (i_sys_rst)
		(irq.take_int || irq.take_nmi) && !irq.en_set |=> !iff_ff)
		else $error("enable latch still set after an accepted interrupt");
endmodule : cbi_irq_ctl

// ### testbench/cbi_mem_model.sv
`timescale 1ns/1ps
module cbi_mem_model
	import cbi_pkg::*;
#(
	parameter logic [7:0] VEC = 8'hA4
)
(
	// Clock
	input  wire logic              i_ref_clk,
	// Bus from the block
	input  wire logic [ADDR_W-1:0] i_addr,
	input  wire logic [DATA_W-1:0] i_wdata,
	input  wire logic              i_data_oe,
	input  wire logic              i_fetch_n,
	input  wire logic              i_memory_request_n,
	input  wire logic              i_io_request_n,
	input  wire logic              i_rd_n,
	input  wire logic              i_wr_n,
	input  wire logic              i_refresh_cycle_flag_n,
	// Slow answer control
	input  wire logic [3:0]        i_wait_clks,
	// Answers
	output logic [DATA_W-1:0]      o_data,
	output logic                   o_wait_n,
	output logic [ADDR_W-1:0]      o_wr_addr,
	output logic [DATA_W-1:0]      o_wr_data
);
	logic [3:0] cnt_ff;
	logic [7:0] last_ff = 8'h00;
	logic       req;
	logic       drv;
	assign req = (!i_memory_request_n && i_refresh_cycle_flag_n) || !i_io_request_n;
	assign drv = (!i_rd_n && req) || (!i_io_request_n && !i_fetch_n);
	always_comb begin
		if (!i_fetch_n && !i_io_request_n)
			o_data = VEC;
		else if (drv && !i_io_request_n)
			o_data = ~i_addr[7:0];
		else if (drv)
			o_data = i_addr[7:0] ^ i_addr[15:8] ^ 8'h5A;
		else
			o_data = ~last_ff; // A released bus must not look like a held byte.
	end
	assign o_wait_n = !(req && cnt_ff < i_wait_clks);
	always_ff @(posedge i_ref_clk) begin
		cnt_ff <= (req && cnt_ff != 4'hF) ? cnt_ff + 4'h1 : (req ? cnt_ff : 4'h0);
		if (drv)
			last_ff <= o_data;
		if (!i_wr_n && i_data_oe) begin
			o_wr_addr <= i_addr;
			o_wr_data <= i_wdata;
		end
	end
endmodule : cbi_mem_model

// ### testbench/testbench.sv
`timescale 1ns/1ps
module testbench;
	import cbi_pkg::*;
	logic         ref_clk = 1'b0;
	logic         sys_rst = 1'b1;
	logic         req = 1'b0, last = 1'b0, halt_exec = 1'b0, pc_load = 1'b0, en_set = 1'b0, en_clr = 1'b0;
	logic         im_wr = 1'b0, ivr_wr = 1'b0, int_n = 1'b1, nmi_n = 1'b1, bus_takeover_request_n = 1'b1;
	cbi_kind_type kind = K_FETCH;
	cbi_mode_type im_val = IM_0, irq_mode, tk_mode;
	logic [15:0]  cyc_addr = 16'h0000, pc_val = 16'h0000, pc, tgt, tk_tgt, addr, wr_addr, raddr;
	logic [7:0]   wdata = 8'h00, ivr_val = 8'h00, rdata, dout, din, mdata, wr_data;
	logic         done, take, nmi, addr_oe, data_oe, ctl_oe, fetch_n, memory_request_n, io_request_n, rd_n, wr_n;
	logic         refresh_cycle_flag_n, halt_n, bus_release_ack_n, wait_n, took, tk_nmi;
	logic [3:0]   wait_clks = 4'h0;
	logic [4:0]   seen;
	int           err_total = 0, comparisons = 0, cyc_cnt = 0;
	always #20 ref_clk = ~ref_clk;
	assign din = data_oe ? dout : mdata;
	always @(posedge ref_clk) begin
		seen <= seen | {~fetch_n, ~memory_request_n & refresh_cycle_flag_n, ~io_request_n, ~refresh_cycle_flag_n, ~wr_n};
		if (!refresh_cycle_flag_n)
			raddr <= addr;
		cyc_cnt++;
		if (cyc_cnt == 5000) begin
			err_total++;
			print_verdict();
		end
	end
	always @(negedge ref_clk) begin
		if (take === 1'b1) begin
			took = 1'b1;
			tk_tgt = tgt;
			tk_nmi = nmi;
			tk_mode = irq_mode;
		end
	end
	cbi_bus_seq dut_u (
		.i_ref_clk(ref_clk), .i_sys_rst(sys_rst), .i_cyc_req(req), .i_cyc_kind(kind),
		.i_cyc_addr(cyc_addr), .i_cyc_wdata(wdata), .i_instr_last(last), .i_halt_exec(halt_exec),
		.i_pc_load(pc_load), .i_pc_val(pc_val), .i_irq_en_set(en_set), .i_irq_en_clr(en_clr),
		.i_im_wr(im_wr), .i_im_val(im_val), .i_ivr_wr(ivr_wr), .i_ivr_val(ivr_val),
		.o_cyc_done(done), .o_rdata(rdata), .o_pc(pc), .o_irq_take(take), .o_irq_nmi(nmi),
		.o_irq_target(tgt), .o_irq_mode(irq_mode), .o_addr(addr), .o_addr_oe(addr_oe), .i_data(din),
		.o_data(dout), .o_data_oe(data_oe), .o_ctl_oe(ctl_oe), .o_fetch_n(fetch_n), .o_memory_request_n(memory_request_n),
		.o_io_request_n(io_request_n), .o_rd_n(rd_n), .o_wr_n(wr_n), .o_refresh_cycle_flag_n(refresh_cycle_flag_n), .o_halt_n(halt_n),
		.o_bus_release_ack_n(bus_release_ack_n), .i_wait_n(wait_n), .i_int_n(int_n), .i_nmi_n(nmi_n), .i_bus_takeover_request_n(bus_takeover_request_n)
	);
	cbi_mem_model part_u (
		.i_ref_clk(ref_clk), .i_addr(addr), .i_wdata(dout), .i_data_oe(data_oe), .i_fetch_n(fetch_n),
		.i_memory_request_n(memory_request_n), .i_io_request_n(io_request_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_refresh_cycle_flag_n(refresh_cycle_flag_n),
		.i_wait_clks(wait_clks), .o_data(mdata), .o_wait_n(wait_n), .o_wr_addr(wr_addr), .o_wr_data(wr_data)
	);
	task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
		comparisons++;
		if (got !== exp) begin
			err_total++;
			$display("unexpected %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	task automatic cyc(input cbi_kind_type k, input logic [15:0] a, input logic [7:0] d, input logic l,
			output int lat);
		@(negedge ref_clk);
		kind = k;
		cyc_addr = a;
		wdata = d;
		last = l;
		req = 1'b1;
		seen = 5'h00;
		lat = 0;
		while (done !== 1'b1 && lat < 100) begin
			@(negedge ref_clk);
			lat++;
		end
		req = 1'b0;
		last = 1'b0;
	endtask : cyc
	task automatic t_fetch();
		int         lat;
		logic [6:0] r0;
		@(negedge ref_clk);
		pc_load = 1'b1;
		pc_val = 16'h0100;
		@(negedge ref_clk);
		pc_load = 1'b0;
		cyc(K_FETCH, 16'h0000, 8'h00, 1'b0, lat);
		chk("fetch length", 16'd9, 16'(lat));
		chk("opcode", 16'h005B, {8'h00, rdata});
		chk("fetch strobes", 16'h001A, {11'h000, seen});
		chk("pc step", 16'h0101, pc);
		r0 = raddr[6:0];
		cyc(K_FETCH, 16'h0000, 8'h00, 1'b0, lat);
		chk("refresh address", {9'h000, r0 + 7'h01}, {9'h000, raddr[6:0]});
		$display("fetch test done");
	endtask : t_fetch
	task automatic t_xfer(input cbi_kind_type k, input logic [15:0] a, input logic [7:0] d, input int n,
			input logic [4:0] strb, input logic [7:0] exp);
		int lat;
		cyc(k, a, d, 1'b0, lat);
		chk("cycle length", 16'(n), 16'(lat));
		chk("strobes", {11'h000, strb}, {11'h000, seen});
		if (k == K_MWR || k == K_IOWR)
			chk("written", {a[7:0], d}, {wr_addr[7:0], wr_data});
		else
			chk("read data", {8'h00, exp}, {8'h00, rdata});
		$display("transfer test kind %0d done", k);
	endtask : t_xfer
	task automatic t_wait();
		int lat;
		// Six slow clocks keep wait low across two samples, so two wait states follow.
		wait_clks = 4'h6;
		cyc(K_MRD, 16'h0002, 8'h00, 1'b0, lat);
		wait_clks = 4'h0;
		chk("waited length", 16'd11, 16'(lat));
		chk("waited data", 16'h0058, {8'h00, rdata});
		$display("wait test done");
	endtask : t_wait
	task automatic t_irq(input cbi_mode_type m, input logic [7:0] pg, input logic en, input logic [15:0] t);
		int lat;
		@(negedge ref_clk);
		im_wr = 1'b1;
		im_val = m;
		ivr_wr = |pg;
		ivr_val = pg;
		en_set = en;
		int_n = 1'b0;
		@(negedge ref_clk);
		im_wr = 1'b0;
		ivr_wr = 1'b0;
		en_set = 1'b0;
		took = 1'b0;
		cyc(K_FETCH, 16'h0000, 8'h00, 1'b0, lat);
		repeat (30) @(negedge ref_clk);
		chk("take before instruction end", 16'h0000, {15'h0000, took});
		cyc(K_FETCH, 16'h0000, 8'h00, 1'b1, lat);
		repeat (30) @(negedge ref_clk);
		int_n = 1'b1;
		chk("take", {15'h0000, en}, {15'h0000, took});
		if (en) begin
			chk("target", t, tk_tgt);
			chk("mode", {14'h0000, m}, {14'h0000, tk_mode});
		end
		$display("interrupt test mode %0d done", m);
	endtask : t_irq
	task automatic t_halt();
		@(negedge ref_clk);
		halt_exec = 1'b1;
		en_set = 1'b1;
		@(negedge ref_clk);
		halt_exec = 1'b0;
		en_set = 1'b0;
		// A disabled latch must keep a maskable request from ending the halt.
		en_clr = 1'b1;
		int_n = 1'b0;
		@(negedge ref_clk);
		en_clr = 1'b0;
		repeat (11) @(negedge ref_clk);
		seen = 5'h00;
		took = 1'b0;
		repeat (30) @(negedge ref_clk);
		chk("halted", 16'h0000, {15'h0000, halt_n});
		chk("halt refresh", 16'h0003, {14'h0000, seen[3], seen[1]});
		nmi_n = 1'b0;
		repeat (40) @(negedge ref_clk);
		nmi_n = 1'b1;
		int_n = 1'b1;
		chk("nmi take", 16'h0003, {14'h0000, took, tk_nmi});
		chk("nmi target", 16'h0066, tk_tgt);
		chk("halt left", 16'h0001, {15'h0000, halt_n});
		$display("halt test done");
	endtask : t_halt
	task automatic t_bus();
		int n;
		@(negedge ref_clk);
		bus_takeover_request_n = 1'b0;
		n = 0;
		while (bus_release_ack_n !== 1'b0 && n < 20) begin
			@(negedge ref_clk);
			n++;
		end
		chk("released", 16'h0000, {12'h000, bus_release_ack_n, addr_oe, data_oe, ctl_oe});
		bus_takeover_request_n = 1'b1;
		repeat (3) @(negedge ref_clk);
		chk("resumed", 16'h0003, {14'h0000, bus_release_ack_n, addr_oe});
		t_xfer(K_MRD, 16'h0304, 8'h00, 7, 5'h08, 8'h5D);
		$display("takeover test done");
	endtask : t_bus
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", comparisons, err_total);
		if (err_total == 0 && comparisons > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (15) @(negedge ref_clk);
		chk("reset pins", 16'h00FF, {5'h00, addr_oe, data_oe, ctl_oe, fetch_n, memory_request_n, io_request_n, rd_n, wr_n,
			refresh_cycle_flag_n, halt_n, bus_release_ack_n});
		chk("reset pc", 16'h0000, pc);
		@(negedge ref_clk);
		sys_rst = 1'b0;
		t_irq(IM_0, 8'h00, 1'b0, 16'h0000);
		t_fetch();
		t_xfer(K_MRD, 16'hFFFF, 8'h00, 7, 5'h08, 8'h5A);
		t_xfer(K_MWR, 16'h8001, 8'hC3, 7, 5'h09, 8'h00);
		t_xfer(K_IORD, 16'h1234, 8'h00, 9, 5'h04, 8'hCB);
		t_xfer(K_IOWR, 16'h0056, 8'h3C, 9, 5'h05, 8'h00);
		t_wait();
		t_irq(IM_2, 8'h00, 1'b1, 16'h00A4);
		t_irq(IM_2, 8'h12, 1'b1, 16'h12A4);
		t_irq(IM_1, 8'h00, 1'b1, 16'h0038);
		t_irq(IM_0, 8'h00, 1'b1, 16'h00A4);
		t_halt();
		t_bus();
		print_verdict();
	end
endmodule : testbench
